// >>> design/ppmc_edge_det.sv
// Purpose: per-bit edge detector with selectable valid edge
// Assumes: inputs synchronous to i_clk
// Notes: one-cycle pulse one edge after the pin edge
module ppmc_edge_det #(
  parameter int W = 1
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst, // synchronous reset, high
  input wire logic [W-1:0] i_sig, // sampled pins
  input wire logic [W-1:0] i_en, // per-bit enable
  input wire ppmc_pkg::ppmc_edge_type [W-1:0] i_sel, // valid edge per bit
  output logic [W-1:0] o_pulse // edge pulses
);
  import ppmc_pkg::*;

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic [W-1:0] pulse_nxt;
  logic valid_r;
  logic valid_nxt;

  // prev is unknown history right after reset: no edge until one sample is held
  assign valid_nxt = `PPMC_ON;
  assign prev_nxt = i_sig;

  for (genvar g = 0; g < W; g++) begin : g_bit
    logic rise;
    logic fall;
    assign rise = i_sig[g] & ~prev_r[g];
    assign fall = ~i_sig[g] & prev_r[g];
    assign pulse_nxt[g] = valid_r & i_en[g] & (
        ((i_sel[g] == EDGE_RISE) & rise) |
        ((i_sel[g] == EDGE_FALL) & fall) |
        ((i_sel[g] == EDGE_BOTH) & (rise | fall)));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_r <= '0;
      valid_r <= `PPMC_OFF;
      o_pulse <= '0;
    end else begin
      prev_r <= prev_nxt;
      valid_r <= valid_nxt;
      o_pulse <= pulse_nxt;
    end
  end

endmodule : ppmc_edge_det

// >>> design/ppmc_pkg.sv
// Purpose: types shared by the pin mode block
// Assumes: ppmc_regs.svh gives widths and reset values
// Notes: configuration travels as one packed struct
`include "ppmc_regs.svh"

package ppmc_pkg;

  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} ppmc_edge_type;

  typedef struct packed {
    logic [`PPMC_P1_W-1:0] p1_mode;
    logic [`PPMC_P1_W-1:0] p1_dir;
    logic [`PPMC_P1_W-1:0] p1_pu;
    logic [`PPMC_P1_W-1:0] p1_latch;
    logic [`PPMC_P2_W-1:0] p2_mode;
    logic [`PPMC_P3_W-1:0] p3_mode;
    logic [`PPMC_P3_W-1:0] p3_dir;
    logic [`PPMC_P3_W-1:0] p3_pu;
    logic [`PPMC_P3_W-1:0] p3_latch;
    logic [`PPMC_P6_W-1:0] p6_dir;
    logic [`PPMC_P6_W-1:0] p6_latch;
    logic [`PPMC_P7_W-1:0] p7_mode;
    logic [`PPMC_P7_W-1:0] p7_dir;
    logic [`PPMC_P7_W-1:0] p7_pu;
    logic [`PPMC_P7_W-1:0] p7_latch;
    logic p12_mode;
    logic p12_dir;
    logic p12_pu;
    logic p12_latch;
    logic p13_latch;
    logic cap_mode;
    ppmc_edge_type [`PPMC_IRQ_N-1:0] irq_edge;
  } ppmc_cfg_type;

  typedef struct packed {
    logic [`PPMC_P1_W-1:0] p1_out;
    logic [`PPMC_P1_W-1:0] p1_oe;
    logic [`PPMC_P3_W-1:0] p3_out;
    logic [`PPMC_P3_W-1:0] p3_oe;
  } ppmc_alt_type;

  localparam ppmc_cfg_type PPMC_CFG_RST = '{
    p1_mode: {`PPMC_P1_W{`PPMC_MODE_PORT}},
    p1_dir: {`PPMC_P1_W{`PPMC_DIR_IN}},
    p1_pu: {`PPMC_P1_W{`PPMC_PU_RST}},
    p1_latch: {`PPMC_P1_W{`PPMC_LATCH_RST}},
    p2_mode: {`PPMC_P2_W{`PPMC_MODE_PORT}},
    p3_mode: {`PPMC_P3_W{`PPMC_MODE_PORT}},
    p3_dir: {`PPMC_P3_W{`PPMC_DIR_IN}},
    p3_pu: {`PPMC_P3_W{`PPMC_PU_RST}},
    p3_latch: {`PPMC_P3_W{`PPMC_LATCH_RST}},
    p6_dir: {`PPMC_P6_W{`PPMC_DIR_IN}},
    p6_latch: {`PPMC_P6_W{`PPMC_LATCH_RST}},
    p7_mode: {`PPMC_P7_W{`PPMC_MODE_PORT}},
    p7_dir: {`PPMC_P7_W{`PPMC_DIR_IN}},
    p7_pu: {`PPMC_P7_W{`PPMC_PU_RST}},
    p7_latch: {`PPMC_P7_W{`PPMC_LATCH_RST}},
    p12_mode: `PPMC_MODE_PORT,
    p12_dir: `PPMC_DIR_IN,
    p12_pu: `PPMC_PU_RST,
    p12_latch: `PPMC_LATCH_RST,
    p13_latch: `PPMC_LATCH_RST,
    cap_mode: `PPMC_MODE_PORT,
    irq_edge: {`PPMC_IRQ_N{EDGE_NONE}}
  };

endpackage : ppmc_pkg

// >>> design/ppmc_regs.svh
// Purpose: named widths, bit positions and reset values of the pin mode block
// Assumes: included by bare name from the package and the top module
// Notes: definitions only
`ifndef PPMC_REGS_SVH
`define PPMC_REGS_SVH

// ****************************************
// port widths
// ****************************************
`define PPMC_P1_W 8
`define PPMC_P2_W 8
`define PPMC_P3_W 4
`define PPMC_P6_W 4
`define PPMC_P7_W 4
`define PPMC_IRQ_N 6

// ****************************************
// interrupt map
// ****************************************
`define PPMC_IRQ0 0
`define PPMC_IRQ1 1
`define PPMC_IRQ4 4
`define PPMC_IRQ5 5
`define PPMC_IRQ5_P1_BIT 6

// ****************************************
// encodings and reset values
// ****************************************
`define PPMC_DIR_IN 1'b1
`define PPMC_MODE_PORT 1'b0
`define PPMC_PU_RST 1'b0
`define PPMC_LATCH_RST 1'b0
`define PPMC_OFF 1'b0
`define PPMC_ON 1'b1
`define PPMC_KEY_IDLE 1'b1

`endif

// >>> design/ppmc_top.sv
// Purpose: per-pin port/control mode, direction and pull-up logic of the I/O ports
// Assumes: pins sampled synchronously; software loads i_cfg with i_cfg_we
// Notes: all outputs registered, so pins follow a configuration load two cycles later
`include "ppmc_regs.svh"

module ppmc_top (
  input wire logic i_clk, // 20 MHz system clock
  input wire logic i_reset, // synchronous reset, high
  input wire logic i_reset_pin_n, // system reset pin, low active
  input wire logic i_cfg_we, // load configuration
  input wire ppmc_pkg::ppmc_cfg_type i_cfg, // configuration value
  input wire ppmc_pkg::ppmc_alt_type i_alt, // alternate function drives
  input wire logic [`PPMC_P1_W-1:0] i_p1_in, // port one pins
  input wire logic [`PPMC_P2_W-1:0] i_p2_in, // port two pins
  input wire logic [`PPMC_P3_W-1:0] i_p3_in, // port three pins
  input wire logic [`PPMC_P6_W-1:0] i_p6_in, // port six pins
  input wire logic [`PPMC_P7_W-1:0] i_p7_in, // port seven pins
  input wire logic i_p12_in, // port12_pin level
  input wire logic i_cap_pin, // capture_trigger_pin level
  output ppmc_pkg::ppmc_cfg_type o_cfg, // configuration readback
  output logic [`PPMC_P1_W-1:0] o_p1_out, // port one drive value
  output logic [`PPMC_P1_W-1:0] o_p1_oe, // port one drive enable
  output logic [`PPMC_P1_W-1:0] o_p1_pu, // port one pull-up enable
  output logic [`PPMC_P1_W-1:0] o_p1_rd, // port one read value
  output logic [`PPMC_P2_W-1:0] o_p2_rd, // port two read value
  output logic [`PPMC_P2_W-1:0] o_analog_channel_inputs, // analog channel select
  output logic [`PPMC_P3_W-1:0] o_p3_out, // port three drive value
  output logic [`PPMC_P3_W-1:0] o_p3_oe, // port three drive enable
  output logic [`PPMC_P3_W-1:0] o_p3_pu, // port three pull-up enable
  output logic [`PPMC_P3_W-1:0] o_p3_rd, // port three read value
  output logic [`PPMC_P6_W-1:0] o_p6_out, // port six drive value
  output logic [`PPMC_P6_W-1:0] o_p6_oe, // port six pull-low enable
  output logic [`PPMC_P6_W-1:0] o_p6_rd, // port six read value
  output logic [`PPMC_P7_W-1:0] o_p7_out, // port seven drive value
  output logic [`PPMC_P7_W-1:0] o_p7_oe, // port seven drive enable
  output logic [`PPMC_P7_W-1:0] o_p7_pu, // port seven pull-up enable
  output logic [`PPMC_P7_W-1:0] o_p7_rd, // port seven read value
  output logic [`PPMC_P7_W-1:0] o_key_irq_inputs, // key levels to controller
  output logic [`PPMC_P7_W-1:0] o_key_irq, // key falling-edge pulses
  output logic o_p12_out, // port12_pin drive value
  output logic o_p12_oe, // port12_pin drive enable
  output logic o_p12_pu, // port12_pin pull-up enable
  output logic o_p12_rd, // port12_pin read value
  output logic o_output_only_pin, // output_only_pin value
  output logic o_output_only_oe, // output_only_pin drive enable
  output logic [`PPMC_IRQ_N-1:0] o_ext_irq, // external interrupt pulses
  output logic o_capture_trigger // to timer16_capture_reg_a
);
  import ppmc_pkg::*;

  // ****************************************
  // reset and configuration
  // ****************************************
  logic rst;
  ppmc_cfg_type cfg_r;
  ppmc_cfg_type cfg_nxt;

  assign rst = i_reset | ~i_reset_pin_n;

  always_comb begin
    cfg_nxt = cfg_r;
    if (i_cfg_we) begin
      cfg_nxt = i_cfg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      cfg_r <= PPMC_CFG_RST;
      o_cfg <= PPMC_CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
      o_cfg <= cfg_nxt;
    end
  end

  // ****************************************
  // port one
  // ****************************************
  logic [`PPMC_P1_W-1:0] p1_ctl;
  logic [`PPMC_P1_W-1:0] p1_drv;
  logic [`PPMC_P1_W-1:0] p1_out_nxt;
  logic [`PPMC_P1_W-1:0] p1_oe_nxt;
  logic [`PPMC_P1_W-1:0] p1_pu_nxt;
  logic [`PPMC_P1_W-1:0] p1_rd_nxt;

  always_comb begin
    p1_ctl = cfg_r.p1_mode ^ {`PPMC_P1_W{`PPMC_MODE_PORT}};
    p1_drv = ~p1_ctl & (cfg_r.p1_dir ^ {`PPMC_P1_W{`PPMC_DIR_IN}});
    p1_out_nxt = (p1_ctl & i_alt.p1_out) | (~p1_ctl & cfg_r.p1_latch);
    p1_oe_nxt = (p1_ctl & i_alt.p1_oe) | p1_drv;
    p1_pu_nxt = ~p1_ctl & cfg_r.p1_pu;
    // an output pin reads back its own latch, not the possibly loaded pin
    p1_rd_nxt = (p1_drv & cfg_r.p1_latch) | (~p1_drv & i_p1_in);
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p1_out <= '0;
      o_p1_oe <= '0;
      o_p1_pu <= '0;
      o_p1_rd <= '0;
    end else begin
      o_p1_out <= p1_out_nxt;
      o_p1_oe <= p1_oe_nxt;
      o_p1_pu <= p1_pu_nxt;
      o_p1_rd <= p1_rd_nxt;
    end
  end

  // ****************************************
  // port two, input only
  // ****************************************
  logic [`PPMC_P2_W-1:0] p2_ctl;
  logic [`PPMC_P2_W-1:0] p2_rd_nxt;

  // no driver and no direction bits exist here at all
  always_comb begin
    p2_ctl = cfg_r.p2_mode ^ {`PPMC_P2_W{`PPMC_MODE_PORT}};
    p2_rd_nxt = ~p2_ctl & i_p2_in;
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p2_rd <= '0;
      o_analog_channel_inputs <= '0;
    end else begin
      o_p2_rd <= p2_rd_nxt;
      o_analog_channel_inputs <= p2_ctl;
    end
  end

  // ****************************************
  // port three
  // ****************************************
  logic [`PPMC_P3_W-1:0] p3_ctl;
  logic [`PPMC_P3_W-1:0] p3_drv;
  logic [`PPMC_P3_W-1:0] p3_out_nxt;
  logic [`PPMC_P3_W-1:0] p3_oe_nxt;
  logic [`PPMC_P3_W-1:0] p3_pu_nxt;
  logic [`PPMC_P3_W-1:0] p3_rd_nxt;

  always_comb begin
    p3_ctl = cfg_r.p3_mode ^ {`PPMC_P3_W{`PPMC_MODE_PORT}};
    p3_drv = ~p3_ctl & (cfg_r.p3_dir ^ {`PPMC_P3_W{`PPMC_DIR_IN}});
    p3_out_nxt = (p3_ctl & i_alt.p3_out) | (~p3_ctl & cfg_r.p3_latch);
    p3_oe_nxt = (p3_ctl & i_alt.p3_oe) | p3_drv;
    p3_pu_nxt = ~p3_ctl & cfg_r.p3_pu;
    p3_rd_nxt = (p3_drv & cfg_r.p3_latch) | (~p3_drv & i_p3_in);
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p3_out <= '0;
      o_p3_oe <= '0;
      o_p3_pu <= '0;
      o_p3_rd <= '0;
    end else begin
      o_p3_out <= p3_out_nxt;
      o_p3_oe <= p3_oe_nxt;
      o_p3_pu <= p3_pu_nxt;
      o_p3_rd <= p3_rd_nxt;
    end
  end

  // ****************************************
  // port six, open drain
  // ****************************************
  logic [`PPMC_P6_W-1:0] p6_drv;
  logic [`PPMC_P6_W-1:0] p6_oe_nxt;
  logic [`PPMC_P6_W-1:0] p6_rd_nxt;

  // only pulls low; a latch of 1 releases the pin, pull-up is a mask option
  always_comb begin
    p6_drv = cfg_r.p6_dir ^ {`PPMC_P6_W{`PPMC_DIR_IN}};
    p6_oe_nxt = p6_drv & ~cfg_r.p6_latch;
    p6_rd_nxt = (p6_drv & cfg_r.p6_latch & i_p6_in) | (~p6_drv & i_p6_in);
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p6_out <= '0;
      o_p6_oe <= '0;
      o_p6_rd <= '0;
    end else begin
      o_p6_out <= '0;
      o_p6_oe <= p6_oe_nxt;
      o_p6_rd <= p6_rd_nxt;
    end
  end

  // ****************************************
  // port seven and key inputs
  // ****************************************
  logic [`PPMC_P7_W-1:0] p7_ctl;
  logic [`PPMC_P7_W-1:0] p7_drv;
  logic [`PPMC_P7_W-1:0] p7_out_nxt;
  logic [`PPMC_P7_W-1:0] p7_oe_nxt;
  logic [`PPMC_P7_W-1:0] p7_pu_nxt;
  logic [`PPMC_P7_W-1:0] p7_rd_nxt;
  logic [`PPMC_P7_W-1:0] key_lvl_nxt;
  ppmc_edge_type [`PPMC_P7_W-1:0] key_sel;

  always_comb begin
    p7_ctl = cfg_r.p7_mode ^ {`PPMC_P7_W{`PPMC_MODE_PORT}};
    p7_drv = ~p7_ctl & (cfg_r.p7_dir ^ {`PPMC_P7_W{`PPMC_DIR_IN}});
    p7_out_nxt = ~p7_ctl & cfg_r.p7_latch;
    p7_oe_nxt = p7_drv;
    // pull-up kept in key mode too, keys usually short to ground
    p7_pu_nxt = cfg_r.p7_pu;
    p7_rd_nxt = (p7_drv & cfg_r.p7_latch) | (~p7_drv & i_p7_in);
    key_lvl_nxt = (p7_ctl & i_p7_in) | (~p7_ctl & {`PPMC_P7_W{`PPMC_KEY_IDLE}});
    key_sel = {`PPMC_P7_W{EDGE_FALL}};
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p7_out <= '0;
      o_p7_oe <= '0;
      o_p7_pu <= '0;
      o_p7_rd <= '0;
      o_key_irq_inputs <= {`PPMC_P7_W{`PPMC_KEY_IDLE}};
    end else begin
      o_p7_out <= p7_out_nxt;
      o_p7_oe <= p7_oe_nxt;
      o_p7_pu <= p7_pu_nxt;
      o_p7_rd <= p7_rd_nxt;
      o_key_irq_inputs <= key_lvl_nxt;
    end
  end

  ppmc_edge_det #(.W(`PPMC_P7_W)) u_key_edge (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_sig(i_p7_in),
    .i_en(p7_ctl),
    .i_sel(key_sel),
    .o_pulse(o_key_irq)
  );

  // ****************************************
  // ports twelve, thirteen, capture pin
  // ****************************************
  logic p12_ctl;
  logic p12_drv;
  logic p12_rd_nxt;
  logic cap_ctl;
  logic [`PPMC_IRQ_N-1:0] irq_sig;
  logic [`PPMC_IRQ_N-1:0] irq_en;

  always_comb begin
    p12_ctl = cfg_r.p12_mode ^ `PPMC_MODE_PORT;
    p12_drv = ~p12_ctl & (cfg_r.p12_dir ^ `PPMC_DIR_IN);
    p12_rd_nxt = p12_drv ? cfg_r.p12_latch : i_p12_in;
    cap_ctl = cfg_r.cap_mode ^ `PPMC_MODE_PORT;
    irq_sig = '0;
    irq_en = '0;
    irq_sig[`PPMC_IRQ0] = i_p12_in;
    irq_en[`PPMC_IRQ0] = p12_ctl;
    irq_sig[`PPMC_IRQ4:`PPMC_IRQ1] = i_p3_in;
    irq_en[`PPMC_IRQ4:`PPMC_IRQ1] = p3_ctl;
    irq_sig[`PPMC_IRQ5] = i_p1_in[`PPMC_IRQ5_P1_BIT];
    irq_en[`PPMC_IRQ5] = p1_ctl[`PPMC_IRQ5_P1_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_p12_out <= `PPMC_LATCH_RST;
      o_p12_oe <= `PPMC_OFF;
      o_p12_pu <= `PPMC_OFF;
      o_p12_rd <= `PPMC_OFF;
      o_output_only_pin <= `PPMC_LATCH_RST;
      o_output_only_oe <= `PPMC_OFF;
      o_capture_trigger <= `PPMC_OFF;
    end else begin
      o_p12_out <= cfg_r.p12_latch & ~p12_ctl;
      o_p12_oe <= p12_drv;
      o_p12_pu <= cfg_r.p12_pu & ~p12_ctl;
      o_p12_rd <= p12_rd_nxt;
      o_output_only_pin <= cfg_r.p13_latch;
      o_output_only_oe <= `PPMC_ON;
      o_capture_trigger <= cap_ctl & i_cap_pin;
    end
  end

  ppmc_edge_det #(.W(`PPMC_IRQ_N)) u_irq_edge (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_sig(irq_sig),
    .i_en(irq_en),
    .i_sel(cfg_r.irq_edge),
    .o_pulse(o_ext_irq)
  );

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);

  sequence s_irq0_rise;
    p12_ctl && cfg_r.irq_edge[`PPMC_IRQ0] == EDGE_RISE && !i_p12_in
    ##1 i_p12_in && $stable(cfg_r);
  endsequence

  sequence s_key0_fall;
    p7_ctl[0] && i_p7_in[0] ##1 !i_p7_in[0] && $stable(cfg_r);
  endsequence

  property p_p1_port_drive;
    1'b1 |=> (o_p1_oe & ~$past(p1_ctl)) ==
      ($past(cfg_r.p1_dir ^ {`PPMC_P1_W{`PPMC_DIR_IN}}) & ~$past(p1_ctl));
  endproperty
  a_p1_port_drive: assert property (p_p1_port_drive) else $error("p1 oe wrong");

  property p_p1_pullup;
    i_cfg_we |=> ##1 o_p1_pu == ($past(i_cfg.p1_pu, 2) &
      ~($past(i_cfg.p1_mode, 2) ^ {`PPMC_P1_W{`PPMC_MODE_PORT}}));
  endproperty
  a_p1_pullup: assert property (p_p1_pullup) else $error("p1 pull-up wrong");

  property p_p6_open_drain;
    o_p6_oe != '0 |-> o_p6_out == '0 && ($past(cfg_r.p6_latch) & o_p6_oe) == '0;
  endproperty
  a_p6_open_drain: assert property (p_p6_open_drain) else $error("p6 drove high");

  property p_key_irq;
    s_key0_fall |=> o_key_irq[0];
  endproperty
  a_key_irq: assert property (p_key_irq) else $error("key edge missed");

  property p_p2_ctl_reads_zero;
    p2_ctl[0] |=> !o_p2_rd[0] && o_analog_channel_inputs[0];
  endproperty
  a_p2_ctl_reads_zero: assert property (p_p2_ctl_reads_zero) else $error("p2 ctl read");

  property p_p13_drives;
    !$past(rst) |-> o_output_only_oe && o_output_only_pin == $past(cfg_r.p13_latch);
  endproperty
  a_p13_drives: assert property (p_p13_drives) else $error("p13 not driven");

  property p_irq0_rise;
    s_irq0_rise |=> o_ext_irq[`PPMC_IRQ0];
  endproperty
  a_irq0_rise: assert property (p_irq0_rise) else $error("irq0 edge missed");

  property p_irq_port_silent;
    !irq_en[`PPMC_IRQ0] |=> !o_ext_irq[`PPMC_IRQ0];
  endproperty
  a_irq_port_silent: assert property (p_irq_port_silent) else $error("irq in port");

  property p_reset_pin;
    @(posedge i_clk) disable iff (i_reset)
    !i_reset_pin_n |=> o_p1_oe == '0 && o_ext_irq == '0 && !o_output_only_oe;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");

  property p_capture;
    cap_ctl && i_cap_pin |=> o_capture_trigger;
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_alt_owns;
    p1_ctl[0] |=> o_p1_out[0] == $past(i_alt.p1_out[0]);
  endproperty
  a_alt_owns: assert property (p_alt_owns) else $error("latch leaked");

endmodule : ppmc_top

// >>> dv/ppmc_board.sv
// Purpose: board circuitry seen by the port pins
// Assumes: drive enables are high while the block drives
// Notes: an undriven pin with no pull-up takes i_ext, which changes every cycle
module ppmc_board (
  input wire logic [20:0] i_oe, // enables: p12,p7,p6,p3,p1
  input wire logic [20:0] i_out, // drive values, same order
  input wire logic [20:0] i_pu, // pull-up enables, same order
  input wire logic [20:0] i_ext, // outside levels
  output logic [20:0] o_pin // resolved levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // port six has no register pull-up, so its bits of i_pu are tied low
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_pu) | (~i_oe & ~i_pu & i_ext);
  end
endmodule : ppmc_board

// >>> dv/ppmc_top_tb_top.sv
// Purpose: self-checking bench of the pin mode block
// Assumes: a behavioural model runs on the same edges as the design
// Notes: every output is compared on every falling edge, o_p7_out and o_p12_out only for bits in port mode
module ppmc_top_tb_top import ppmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_reset = 1, i_reset_pin_n = 1, i_cfg_we = 0, i_cap_pin = 0;
  ppmc_cfg_type i_cfg = PPMC_CFG_RST, o_cfg, c, xcfg;
  ppmc_alt_type i_alt = '0;
  logic [7:0] i_p1_in, i_p2_in = 0, o_p1_out, o_p1_oe, o_p1_pu, o_p1_rd, o_p2_rd;
  logic [7:0] o_analog_channel_inputs;
  logic [3:0] i_p3_in, i_p6_in, i_p7_in, o_p3_out, o_p3_oe, o_p3_pu, o_p3_rd;
  logic [3:0] o_p6_out, o_p6_oe, o_p6_rd, o_p7_out, o_p7_oe, o_p7_pu, o_p7_rd;
  logic [3:0] o_key_irq_inputs, o_key_irq, x7o, m7, x12;
  logic i_p12_in, o_p12_out, o_p12_oe, o_p12_pu, o_p12_rd, o_output_only_pin;
  logic o_output_only_oe, o_capture_trigger, xc, hv = 0, chk = 0, m12;
  logic [5:0] o_ext_irq, xi, s, md;
  logic [20:0] ext = 0;
  logic [31:0] r, x1;
  logic [15:0] x2, x3;
  logic [11:0] x6;
  logic [19:0] x7;
  logic [9:0] pv = 0;
  logic [1:0] x13;
  int seed = 32'hf0de7e0a;
  int fail_count = 0, compares = 0, cyc = 0;

  ppmc_top DUT (.i_clk, .i_reset, .i_reset_pin_n, .i_cfg_we, .i_cfg, .i_alt, .i_p1_in,
    .i_p2_in, .i_p3_in, .i_p6_in, .i_p7_in, .i_p12_in, .i_cap_pin, .o_cfg, .o_p1_out,
    .o_p1_oe, .o_p1_pu, .o_p1_rd, .o_p2_rd, .o_analog_channel_inputs, .o_p3_out, .o_p3_oe,
    .o_p3_pu, .o_p3_rd, .o_p6_out, .o_p6_oe, .o_p6_rd, .o_p7_out, .o_p7_oe, .o_p7_pu,
    .o_p7_rd, .o_key_irq_inputs, .o_key_irq, .o_p12_out, .o_p12_oe, .o_p12_pu, .o_p12_rd,
    .o_output_only_pin, .o_output_only_oe, .o_ext_irq, .o_capture_trigger);

  ppmc_board board (.i_oe({o_p12_oe, o_p7_oe, o_p6_oe, o_p3_oe, o_p1_oe}),
    .i_out({o_p12_out, o_p7_out, o_p6_out, o_p3_out, o_p1_out}),
    .i_pu({o_p12_pu, o_p7_pu, 4'h0, o_p3_pu, o_p1_pu}), .i_ext(ext),
    .o_pin({i_p12_in, i_p7_in, i_p6_in, i_p3_in, i_p1_in}));

  always #25 i_clk = ~i_clk;

  // {out, oe, pull-up, read} of one port from mode, dir, pull-up, latch, alt, pins
  function automatic logic [31:0] pm(input logic [7:0] m, d, u, l, ao, ae, p);
    pm = {(m & ao) | (~m & l), (m & ae) | (~m & ~d), ~m & u, (~m & ~d & l) | ((m | d) & p)};
  endfunction : pm

  // ****************************************
  // model
  // ****************************************
  always @(posedge i_clk) begin
    x1 = pm(c.p1_mode, c.p1_dir, c.p1_pu, c.p1_latch, i_alt.p1_out, i_alt.p1_oe, i_p1_in);
    r = pm(c.p3_mode, c.p3_dir, c.p3_pu, c.p3_latch, i_alt.p3_out, i_alt.p3_oe, i_p3_in);
    x3 = {r[27:24], r[19:16], r[11:8], r[3:0]};
    x2 = {i_p2_in & ~c.p2_mode, c.p2_mode};
    // open drain: a released pin (latch 1) reads the line, not the latch
    x6 = {4'h0, ~c.p6_dir & ~c.p6_latch, i_p6_in & (c.p6_dir | c.p6_latch)};
    r = pm(c.p7_mode, c.p7_dir, 0, c.p7_latch, 0, 0, i_p7_in);
    x7 = {r[19:16], c.p7_pu, r[3:0], (c.p7_mode & i_p7_in) | ~c.p7_mode,
      {4{hv}} & c.p7_mode & pv[9:6] & ~i_p7_in};
    x7o = r[27:24];
    m7 = ~c.p7_mode;
    r = pm(c.p12_mode, c.p12_dir, c.p12_pu, c.p12_latch, 0, 0, i_p12_in);
    x12 = {r[16], r[8], r[0], r[24]};
    m12 = ~c.p12_mode;
    x13 = {c.p13_latch, 1'b1};
    xc = c.cap_mode & i_cap_pin;
    s = {i_p1_in[6], i_p3_in, i_p12_in};
    md = {c.p1_mode[6], c.p3_mode, c.p12_mode};
    for (int i = 0; i < 6; i++) begin
      case (c.irq_edge[i])
        EDGE_RISE: xi[i] = ~pv[i] & s[i];
        EDGE_FALL: xi[i] = pv[i] & ~s[i];
        EDGE_BOTH: xi[i] = pv[i] ^ s[i];
        default: xi[i] = 1'b0;
      endcase
      xi[i] = xi[i] & md[i] & hv;
    end
    pv = {i_p7_in, s};
    if (i_reset || !i_reset_pin_n) begin
      {x1, x2, x3, x6, x7o, x12, x13, xi, xc} = '0;
      x7 = {12'h0, 4'hf, 4'h0};
      c = PPMC_CFG_RST;
      hv = 0;
    end else begin
      hv = 1;
      if (i_cfg_we) begin
        c = i_cfg;
      end
    end
    xcfg = c;
    chk = 1;
  end

  task automatic check(input logic [127:0] sv, ev);
    compares++;
    if (sv !== ev) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, sv, ev);
    end
  endtask : check

  always @(negedge i_clk) begin
    if (chk) begin
      check(o_cfg, xcfg);
      check({o_p1_out, o_p1_oe, o_p1_pu, o_p1_rd}, x1);
      check({o_p2_rd, o_analog_channel_inputs}, x2);
      check({o_p3_out, o_p3_oe, o_p3_pu, o_p3_rd}, x3);
      check({o_p6_out, o_p6_oe, o_p6_rd}, x6);
      check({o_p7_oe, o_p7_pu, o_p7_rd, o_key_irq_inputs, o_key_irq}, x7);
      check(o_p7_out & m7, x7o & m7);
      check({o_p12_oe, o_p12_pu, o_p12_rd, o_p12_out & m12}, x12);
      check({o_output_only_pin, o_output_only_oe}, x13);
      check(o_ext_irq, xi);
      check(o_capture_trigger, xc);
    end
  end

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // a hang is cut short well above the planned run of about 1700 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic ppmc_cfg_type rc();
    logic [127:0] v;
    v = {$random(seed), $random(seed), $random(seed), $random(seed)};
    return ppmc_cfg_type'(v[$bits(ppmc_cfg_type)-1:0]);
  endfunction : rc

  task automatic step(input logic we, input ppmc_cfg_type v);
    @(posedge i_clk);
    ext <= 21'($random(seed));
    i_p2_in <= 8'($random(seed));
    i_cap_pin <= 1'($random(seed));
    i_alt <= ppmc_alt_type'(24'($random(seed)));
    i_cfg_we <= we;
    i_cfg <= v;
  endtask : step

  // ****************************************
  // tests
  // ****************************************
  initial begin
    ppmc_cfg_type v;
    repeat (5) @(posedge i_clk);
    i_reset <= 0;
    repeat (1500) step(($random(seed) & 7) == 0, rc());
    $display("test random done");
    for (int e = 0; e < 4; e++) begin
      v = rc();
      v.irq_edge = {6{ppmc_edge_type'(e)}};
      {v.p12_mode, v.p3_mode, v.p1_mode[6], v.p7_mode} = '1;
      {v.p6_dir, v.p6_latch} = '0;
      step(1, v);
      repeat (40) step(0, v);
    end
    $display("test edges done");
    @(posedge i_clk);
    i_reset_pin_n <= 0;
    repeat (3) step(1, rc());
    i_reset_pin_n <= 1;
    repeat (20) step(1, rc());
    i_reset <= 1;
    step(0, rc());
    i_reset <= 0;
    repeat (20) step(($random(seed) & 1) == 0, rc());
    $display("test reset done");
    step(0, rc());
    final_report();
  end
endmodule : ppmc_top_tb_top
